// ---- design/t16wm_pkg.sv ----
// Package for the 16-bit timer waveform mode and compare output block
package t16wm_pkg;

    // Register port addresses (byte wide registers)
    localparam logic [3:0] ADDR_CTRL_A    = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B    = 4'h1;
    localparam logic [3:0] ADDR_CMP_A_LO  = 4'h2;
    localparam logic [3:0] ADDR_CMP_A_HI  = 4'h3;
    localparam logic [3:0] ADDR_CMP_B_LO  = 4'h4;
    localparam logic [3:0] ADDR_CMP_B_HI  = 4'h5;
    localparam logic [3:0] ADDR_CAPT_LO   = 4'h6;
    localparam logic [3:0] ADDR_CAPT_HI   = 4'h7;
    localparam logic [3:0] ADDR_STATUS    = 4'h8;
    localparam logic [3:0] ADDR_CNT_LO    = 4'h9;
    localparam logic [3:0] ADDR_CNT_HI    = 4'hA;

    // Field positions in control register A
    localparam int CTRL_A_MODE_A_POS  = 6;
    localparam int CTRL_A_MODE_B_POS  = 4;
    localparam int CTRL_A_FORCE_A_POS = 3;
    localparam int CTRL_A_FORCE_B_POS = 2;
    localparam int CTRL_A_WGM_LO_POS  = 0;
    // Field position in control register B
    localparam int CTRL_B_WGM_HI_POS  = 3;
    // Status register bits
    localparam int STAT_OVF_POS       = 0;
    localparam int STAT_CMPA_POS      = 1;
    localparam int STAT_CMPB_POS      = 2;
    localparam int STAT_CAPT_POS      = 3;
    localparam int STAT_DOWN_POS      = 4;

    // Reset values
    localparam logic [7:0]  CTRL_A_RESET  = 8'h00;
    localparam logic [7:0]  CTRL_B_RESET  = 8'h00;
    localparam logic [15:0] VALUE_RESET   = 16'h0000;

    // Count limits
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] BOTTOM    = 16'h0000;

    // Output mode encodings
    localparam logic [1:0] OMODE_OFF    = 2'h0;
    localparam logic [1:0] OMODE_TOGGLE = 2'h1;
    localparam logic [1:0] OMODE_CLEAR  = 2'h2;
    localparam logic [1:0] OMODE_SET    = 2'h3;

    // Waveform modes named for the channel A toggle; only 9 and 15 allow it
    localparam logic [3:0] WGM_PFC_CMPA  = 4'h9;
    localparam logic [3:0] WGM_PC_CMPA   = 4'hB;
    localparam logic [3:0] WGM_FAST_CAPT = 4'hE;
    localparam logic [3:0] WGM_FAST_CMPA = 4'hF;

    // Mode class decoded from the waveform mode
    typedef enum logic [2:0] {
        T16WM_NORMAL,
        T16WM_CTC,
        T16WM_FAST,
        T16WM_PHASE,
        T16WM_PFC,
        T16WM_RSVD
    } t16wm_class_type;

    typedef enum logic [1:0] {
        T16WM_TOP_FIXED,
        T16WM_TOP_CMPA,
        T16WM_TOP_CAPT
    } t16wm_topsrc_type;

    // Decoded mode bundle
    typedef struct packed {
        t16wm_class_type  cls;
        t16wm_topsrc_type src;
        logic [15:0]      fixed_top;
    } t16wm_decode_type;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } t16wm_bus_type;

    // Pin side outputs of one channel
    typedef struct packed {
        logic level;
        logic override;
        logic drive_en;
    } t16wm_pin_type;

endpackage

// ---- design/t16wm_top.sv ----
// Waveform mode decode, counter and compare output control of a 16-bit timer
// Operation
// - All logic on one clock, tick enables
// - Nonzero output mode overrides pin function, except a toggle the mode does not allow
// - Pin driven only when direction is output
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM: clear/set on match, inverse at TOP
// - Fast toggle only channel A, mode 15
// - Fast clear/set: compare at TOP ignored, TOP acts
// - Dual slope: up-match and down-match opposite
// - Dual slope toggle only A, mode 9
// - Force applies match in non-PWM only
// - Force sets no flag, no clear
// - Force bits read as zero
// - Force is strobe using the mode written with it
// - Mode = two B bits over A bits
// - Phase correct TOPs, reload TOP, flag BOTTOM
// - Fast PWM TOPs, reload and flag TOP
// - Modes 8/9 reload and flag BOTTOM
// - Normal/CTC immediate reload, flag MAX
// - Dual slope counts BOTTOM to TOP back
`timescale 1ns/1ps
`default_nettype none

module t16wm_top (
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    input  wire logic [3:0]                bus_addr,
    input  wire logic [7:0]                bus_wdata,
    input  wire logic                      bus_wr,
    input  wire logic                      bus_rd,
    output logic [7:0]                     bus_rdata,
    input  wire logic                      timer_tick_enable,
    input  wire logic                      capture_event,
    input  wire logic                      dir_out_a,
    input  wire logic                      dir_out_b,
    output t16wm_pkg::t16wm_pin_type       pin_a,
    output t16wm_pkg::t16wm_pin_type       pin_b
);
    import t16wm_pkg::*;

    // Decode a 4-bit waveform mode into class, TOP source and fixed TOP
    function automatic t16wm_decode_type decode_mode(input logic [3:0] m);
        t16wm_decode_type d;
        d.cls       = T16WM_NORMAL;
        d.src       = T16WM_TOP_FIXED;
        d.fixed_top = COUNT_MAX;
        case (m)
            4'h0: begin
                d.cls = T16WM_NORMAL;
            end
            4'h1, 4'h2, 4'h3: begin
                d.cls = T16WM_PHASE;
            end
            4'h4: begin
                d.cls = T16WM_CTC;
                d.src = T16WM_TOP_CMPA;
            end
            4'h5, 4'h6, 4'h7: begin
                d.cls = T16WM_FAST;
            end
            4'h8: begin
                d.cls = T16WM_PFC;
                d.src = T16WM_TOP_CAPT;
            end
            4'h9: begin
                d.cls = T16WM_PFC;
                d.src = T16WM_TOP_CMPA;
            end
            4'hA: begin
                d.cls = T16WM_PHASE;
                d.src = T16WM_TOP_CAPT;
            end
            4'hB: begin
                d.cls = T16WM_PHASE;
                d.src = T16WM_TOP_CMPA;
            end
            4'hC: begin
                d.cls = T16WM_CTC;
                d.src = T16WM_TOP_CAPT;
            end
            4'hE: begin
                d.cls = T16WM_FAST;
                d.src = T16WM_TOP_CAPT;
            end
            4'hF: begin
                d.cls = T16WM_FAST;
                d.src = T16WM_TOP_CMPA;
            end
            default: begin
                d.cls = T16WM_RSVD;
            end
        endcase
        // Fixed TOP chosen by the low two mode bits
        case (m[1:0])
            2'h1:    d.fixed_top = TOP_8BIT;
            2'h2:    d.fixed_top = TOP_9BIT;
            2'h3:    d.fixed_top = TOP_10BIT;
            default: d.fixed_top = COUNT_MAX;
        endcase
        return d;
    endfunction

    // Next output level for one channel on the events of this tick
    function automatic logic wave_next(
        input logic            cur,
        input logic [1:0]      omode,
        input logic            tog_ok,
        input t16wm_class_type cls,
        input logic            match,
        input logic            at_top,
        input logic            down,
        input logic            force_hit
    );
        logic nxt;
        nxt = cur;
        case (cls)
            T16WM_NORMAL, T16WM_CTC: begin
                if (match || force_hit) begin
                    case (omode)
                        OMODE_TOGGLE: nxt = ~cur;
                        OMODE_CLEAR:  nxt = 1'b0;
                        OMODE_SET:    nxt = 1'b1;
                        default:      nxt = cur;
                    endcase
                end
            end
            T16WM_FAST: begin
                if (omode[1] && at_top) begin
                    nxt = (omode == OMODE_CLEAR);
                end else if (omode[1] && match) begin
                    nxt = (omode == OMODE_SET);
                end else if (omode == OMODE_TOGGLE && tog_ok && match) begin
                    nxt = ~cur;
                end
            end
            T16WM_PHASE, T16WM_PFC: begin
                if (omode[1] && match) begin
                    nxt = (omode == OMODE_SET) ^ down;
                end else if (omode == OMODE_TOGGLE && tog_ok && match) begin
                    nxt = ~cur;
                end
            end
            default: nxt = cur;
        endcase
        return nxt;
    endfunction

    // PWM class test, shared by the live mode and the mode written with a force
    function automatic logic class_is_pwm(input t16wm_class_type c);
        return (c == T16WM_FAST) || (c == T16WM_PHASE) || (c == T16WM_PFC);
    endfunction

    // Registers
    logic [7:0]  ctrl_a_reg;
    logic [7:0]  ctrl_b_reg;
    logic [15:0] cmp_a_buf_reg;
    logic [15:0] cmp_b_buf_reg;
    logic [15:0] cmp_a_reg;
    logic [15:0] cmp_b_reg;
    logic [15:0] capt_reg;
    logic [15:0] count_reg;
    logic        down_reg;
    logic        ovf_reg;
    logic        cmpa_flag_reg;
    logic        cmpb_flag_reg;
    logic        capt_flag_reg;
    logic        wave_a_reg;
    logic        wave_b_reg;
    logic [7:0]  rdata_reg;
    t16wm_pin_type pin_a_reg;
    t16wm_pin_type pin_b_reg;

    // Bus request bundle and strobes
    t16wm_bus_type req;
    assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
    wire wr_ctrl_a = req.wr && (req.addr == ADDR_CTRL_A);
    wire wr_ctrl_b = req.wr && (req.addr == ADDR_CTRL_B);
    wire wr_st     = req.wr && (req.addr == ADDR_STATUS);

    // Mode fields
    wire [1:0] mode_a = ctrl_a_reg[CTRL_A_MODE_A_POS +: 2];
    wire [1:0] mode_b = ctrl_a_reg[CTRL_A_MODE_B_POS +: 2];
    wire [3:0] waveform_mode = {ctrl_b_reg[CTRL_B_WGM_HI_POS +: 2],
                                ctrl_a_reg[CTRL_A_WGM_LO_POS +: 2]};
    t16wm_decode_type dec;
    assign dec = decode_mode(waveform_mode);

    wire is_pwm  = class_is_pwm(dec.cls);
    wire is_dual = (dec.cls == T16WM_PHASE) || (dec.cls == T16WM_PFC);

    // TOP selection
    wire [15:0] top_val = (dec.src == T16WM_TOP_CMPA) ? cmp_a_reg :
                          (dec.src == T16WM_TOP_CAPT) ? capt_reg  : dec.fixed_top;

    // Count position events; matches and tick_top qualified by the timer tick only
    wire at_top    = (count_reg == top_val);
    wire at_bottom = (count_reg == BOTTOM);
    wire at_max    = (count_reg == COUNT_MAX);
    wire match_a   = timer_tick_enable && (count_reg == cmp_a_reg);
    wire match_b   = timer_tick_enable && (count_reg == cmp_b_reg);
    wire tick_top  = timer_tick_enable && at_top;

    // Fast PWM ignores a match sitting at TOP when the upper mode bit is set
    wire fast_mask_a = (dec.cls == T16WM_FAST) && mode_a[1] && (cmp_a_reg == top_val);
    wire fast_mask_b = (dec.cls == T16WM_FAST) && mode_b[1] && (cmp_b_reg == top_val);
    wire eff_match_a = match_a && !fast_mask_a;
    wire eff_match_b = match_b && !fast_mask_b;

    // Channel A toggle allowed in non-PWM modes and modes 9 and 15; channel B only in non-PWM modes
    wire tog_ok_a = (dec.cls == T16WM_FAST) ? (waveform_mode == WGM_FAST_CMPA) :
                    is_dual ? (waveform_mode == WGM_PFC_CMPA ||
                               waveform_mode == WGM_FAST_CAPT) : 1'b1;
    wire tog_ok_b = !is_pwm;
    wire conn_a   = (mode_a != OMODE_OFF) && (mode_a != OMODE_TOGGLE || tog_ok_a);
    wire conn_b   = (mode_b != OMODE_OFF) && (mode_b != OMODE_TOGGLE || tog_ok_b);

    // Force strobes live only during the write cycle and are judged against the value
    // written beside them, so one write can pick an output mode and fire it
    wire [3:0] force_wgm = {ctrl_b_reg[CTRL_B_WGM_HI_POS +: 2], req.wdata[CTRL_A_WGM_LO_POS +: 2]};
    t16wm_decode_type force_dec;
    assign force_dec = decode_mode(force_wgm);
    wire force_pwm = class_is_pwm(force_dec.cls);
    wire force_a = wr_ctrl_a && req.wdata[CTRL_A_FORCE_A_POS] && !force_pwm;
    wire force_b = wr_ctrl_a && req.wdata[CTRL_A_FORCE_B_POS] && !force_pwm;
    wire [1:0] omode_a = force_a ? req.wdata[CTRL_A_MODE_A_POS +: 2] : mode_a;
    wire [1:0] omode_b = force_b ? req.wdata[CTRL_A_MODE_B_POS +: 2] : mode_b;

    // Counter step: single slope wraps at TOP, dual slope turns at TOP and BOTTOM
    wire ctc_or_fast = (dec.cls == T16WM_CTC) || (dec.cls == T16WM_FAST);
    wire [15:0] count_inc = count_reg + 16'h0001;
    wire [15:0] count_dec = count_reg - 16'h0001;
    wire        turn_down = is_dual && at_top;
    wire        turn_up   = is_dual && at_bottom;
    wire        dir_down  = turn_down ? 1'b1 : (turn_up ? 1'b0 : down_reg);
    wire [15:0] count_step = is_dual ? (dir_down ? count_dec : count_inc) :
                             (ctc_or_fast && at_top) ? BOTTOM : count_inc;
    // Reaching TOP clears in CTC; a forced match never does
    wire [15:0] count_next = timer_tick_enable ? count_step : count_reg;
    wire        down_next  = timer_tick_enable ? dir_down : down_reg;

    // Compare buffer reload point per mode class
    wire reload_now = (dec.cls == T16WM_NORMAL) || (dec.cls == T16WM_CTC) ||
                      (dec.cls == T16WM_RSVD);
    wire reload_evt = reload_now ? 1'b1 :
                      (dec.cls == T16WM_PFC) ? (timer_tick_enable && at_bottom) :
                      tick_top;
    // Overflow flag point per mode class
    wire ovf_evt = timer_tick_enable && (is_dual ? at_bottom :
                   (dec.cls == T16WM_FAST) ? at_top : at_max);
    wire capt_evt = (dec.src == T16WM_TOP_CAPT) ? tick_top : capture_event;

    // Waveform next levels; fast PWM TOP action survives the masked match
    wire wave_a_next = wave_next(wave_a_reg, omode_a, tog_ok_a, dec.cls, eff_match_a,
                                 tick_top, down_reg, force_a);
    wire wave_b_next = wave_next(wave_b_reg, omode_b, tog_ok_b, dec.cls, eff_match_b,
                                 tick_top, down_reg, force_b);

    // Pin side bundles: override when connected, drive when direction is output
    t16wm_pin_type pin_a_next;
    t16wm_pin_type pin_b_next;
    assign pin_a_next = '{level: wave_a_next, override: conn_a, drive_en: conn_a && dir_out_a};
    assign pin_b_next = '{level: wave_b_next, override: conn_b, drive_en: conn_b && dir_out_b};

    // Read mux; force bits always read back as zero
    wire [7:0] ctrl_a_view = ctrl_a_reg & ~(8'h01 << CTRL_A_FORCE_A_POS) & ~(8'h01 << CTRL_A_FORCE_B_POS);
    wire [7:0] status_view = {3'h0, down_reg, capt_flag_reg, cmpb_flag_reg, cmpa_flag_reg, ovf_reg};
    logic [7:0] rd_mux;
    always_comb begin
        case (req.addr)
            ADDR_CTRL_A:   rd_mux = ctrl_a_view;
            ADDR_CTRL_B:   rd_mux = ctrl_b_reg & 8'hDF;
            ADDR_CMP_A_LO: rd_mux = cmp_a_buf_reg[7:0];
            ADDR_CMP_A_HI: rd_mux = cmp_a_buf_reg[15:8];
            ADDR_CMP_B_LO: rd_mux = cmp_b_buf_reg[7:0];
            ADDR_CMP_B_HI: rd_mux = cmp_b_buf_reg[15:8];
            ADDR_CAPT_LO:  rd_mux = capt_reg[7:0];
            ADDR_CAPT_HI:  rd_mux = capt_reg[15:8];
            ADDR_STATUS:   rd_mux = status_view;
            ADDR_CNT_LO:   rd_mux = count_reg[7:0];
            ADDR_CNT_HI:   rd_mux = count_reg[15:8];
            default:       rd_mux = 8'h00;
        endcase
    end

    // Control registers; force bits are never stored
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_a_reg <= CTRL_A_RESET;
            ctrl_b_reg <= CTRL_B_RESET;
        end else begin
            if (wr_ctrl_a) ctrl_a_reg <= req.wdata & 8'hF3;
            if (wr_ctrl_b) ctrl_b_reg <= req.wdata & 8'hDF;
        end
    end

    // Compare buffers written by software, live copies reloaded per mode
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmp_a_buf_reg <= VALUE_RESET;
            cmp_b_buf_reg <= VALUE_RESET;
            capt_reg      <= VALUE_RESET;
        end else begin
            if (req.wr && req.addr == ADDR_CMP_A_LO) cmp_a_buf_reg[7:0]  <= req.wdata;
            if (req.wr && req.addr == ADDR_CMP_A_HI) cmp_a_buf_reg[15:8] <= req.wdata;
            if (req.wr && req.addr == ADDR_CMP_B_LO) cmp_b_buf_reg[7:0]  <= req.wdata;
            if (req.wr && req.addr == ADDR_CMP_B_HI) cmp_b_buf_reg[15:8] <= req.wdata;
            if (req.wr && req.addr == ADDR_CAPT_LO)  capt_reg[7:0]       <= req.wdata;
            if (req.wr && req.addr == ADDR_CAPT_HI)  capt_reg[15:8]      <= req.wdata;
            if (capture_event && dec.src != T16WM_TOP_CAPT) capt_reg <= count_reg;
        end
    end

    // Live compare values follow the buffers at the reload point
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmp_a_reg <= VALUE_RESET;
            cmp_b_reg <= VALUE_RESET;
        end else if (reload_evt) begin
            cmp_a_reg <= cmp_a_buf_reg;
            cmp_b_reg <= cmp_b_buf_reg;
        end
    end

    // Counter and direction
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_reg <= VALUE_RESET;
            down_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            down_reg  <= down_next;
        end
    end

    // Sticky flags, write one to clear; a new event wins over the clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ovf_reg       <= 1'b0;
            cmpa_flag_reg <= 1'b0;
            cmpb_flag_reg <= 1'b0;
            capt_flag_reg <= 1'b0;
        end else begin
            ovf_reg       <= ovf_evt  | (ovf_reg       & ~(wr_st & req.wdata[STAT_OVF_POS]));
            cmpa_flag_reg <= match_a  | (cmpa_flag_reg & ~(wr_st & req.wdata[STAT_CMPA_POS]));
            cmpb_flag_reg <= match_b  | (cmpb_flag_reg & ~(wr_st & req.wdata[STAT_CMPB_POS]));
            capt_flag_reg <= capt_evt | (capt_flag_reg & ~(wr_st & req.wdata[STAT_CAPT_POS]));
        end
    end

    // Waveform levels, pin bundles and read data, all registered
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wave_a_reg <= 1'b0;
            wave_b_reg <= 1'b0;
            pin_a_reg  <= '0;
            pin_b_reg  <= '0;
            rdata_reg  <= 8'h00;
        end else begin
            wave_a_reg <= wave_a_next;
            wave_b_reg <= wave_b_next;
            pin_a_reg  <= pin_a_next;
            pin_b_reg  <= pin_b_next;
            rdata_reg  <= req.rd ? rd_mux : 8'h00;
        end
    end

    assign bus_rdata = rdata_reg;
    assign pin_a     = pin_a_reg;
    assign pin_b     = pin_b_reg;

endmodule

`default_nettype wire

// ---- test/t16wm_chk.sv ----
// Assertion checker for the timer waveform mode block
`timescale 1ns/1ps
`default_nettype none
module t16wm_chk (
    input wire logic                     clk_sys,
    input wire logic                     resetn,
    input wire logic [3:0]               bus_addr,
    input wire logic [7:0]               bus_wdata,
    input wire logic                     bus_wr,
    input wire logic                     bus_rd,
    input wire logic [7:0]               bus_rdata,
    input wire logic                     timer_tick_enable,
    input wire logic                     capture_event,
    input wire logic                     dir_out_a,
    input wire logic                     dir_out_b,
    input wire t16wm_pkg::t16wm_pin_type pin_a,
    input wire t16wm_pkg::t16wm_pin_type pin_b
);
    import t16wm_pkg::*;
    logic [1:0] wgm_hi_reg;
    // Mode a control A write would select, judged with the shadowed upper bits
    wire [3:0] wgm     = {wgm_hi_reg, bus_wdata[1:0]};
    wire       non_pwm = wgm inside {4'h0, 4'h4, 4'hC};
    wire       tog_ok  = non_pwm || wgm inside {WGM_PFC_CMPA, WGM_FAST_CMPA};
    wire       pwm     = !non_pwm && wgm != 4'hD;
    // Shadow of control B, since the mode spans two registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) wgm_hi_reg <= 2'h0;
        else if (bus_wr && bus_addr == ADDR_CTRL_B) wgm_hi_reg <= bus_wdata[4:3];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Write and force steps seen on the register port
    sequence s_wr_a; bus_wr && bus_addr == ADDR_CTRL_A; endsequence
    sequence s_force_a; s_wr_a ##0 (bus_wdata[3] && !timer_tick_enable); endsequence
    property p_drive; (pin_a.drive_en == (pin_a.override && $past(dir_out_a)))
        && (pin_b.drive_en == (pin_b.override && $past(dir_out_b))); endproperty
    property p_rd_force; $past(bus_rd) && $past(bus_addr) == ADDR_CTRL_A |-> bus_rdata[3:2] == 2'h0; endproperty
    property p_off; s_wr_a ##0 bus_wdata[7:6] == OMODE_OFF |-> ##2 !pin_a.override; endproperty
    property p_on; s_wr_a ##0 (bus_wdata[7] && wgm != 4'hD) |-> ##2 pin_a.override; endproperty
    property p_tog_a; s_wr_a ##0 bus_wdata[7:6] == OMODE_TOGGLE |-> ##2 pin_a.override == $past(tog_ok, 2); endproperty
    property p_tog_b; s_wr_a ##0 bus_wdata[5:4] == OMODE_TOGGLE |-> ##2 pin_b.override == $past(non_pwm, 2); endproperty
    property p_fclr; s_force_a ##0 (non_pwm && bus_wdata[7:6] == OMODE_CLEAR) |=> !pin_a.level; endproperty
    property p_fset; s_force_a ##0 (non_pwm && bus_wdata[7:6] == OMODE_SET) |=> pin_a.level; endproperty
    property p_ftog; s_force_a ##0 (non_pwm && bus_wdata[7:6] == OMODE_TOGGLE)
        |=> pin_a.level != $past(pin_a.level); endproperty
    property p_fpwm; s_force_a ##0 pwm |=> $stable(pin_a.level); endproperty
    a_drive: assert property (p_drive) else $error("pin drive enable wrong");
    a_rd_force: assert property (p_rd_force) else $error("force bits read nonzero");
    a_off: assert property (p_off) else $error("output mode off still owns pin");
    a_on: assert property (p_on) else $error("output mode does not own pin");
    a_tog_a: assert property (p_tog_a) else $error("channel A toggle ownership wrong");
    a_tog_b: assert property (p_tog_b) else $error("channel B toggle ownership wrong");
    a_fclr: assert property (p_fclr) else $error("forced clear missed");
    a_fset: assert property (p_fset) else $error("forced set missed");
    a_ftog: assert property (p_ftog) else $error("forced toggle missed");
    a_fpwm: assert property (p_fpwm) else $error("force acted in PWM mode");
endmodule
`default_nettype wire

// ---- test/t16wm_tb_top.sv ----
// Self-checking testbench for the timer waveform mode block
`timescale 1ns/1ps
`default_nettype none
module t16wm_tb_top;
    import t16wm_pkg::*;
    logic          clk_sys = 1'b0, resetn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, rd_d = 1'b0, lvl;
    logic          tick = 1'b0, cap = 1'b0, dir_a = 1'b1, dir_b = 1'b1;
    logic [3:0]    bus_addr = 4'h0, om[11] = '{4'h0, 4'h4, 4'hC, 4'h5, 4'hF, 4'h1, 4'h9, 4'hE, 4'hB, 4'h8, 4'hA};
    logic [7:0]    bus_wdata = 8'h00, fa[3] = '{8'hAC, 8'hFC, 8'h5C};
    logic [10:0]   oa = 11'b00001010111, ob = 11'b00000000111;
    logic [31:0]   seed = 32'hB43B9D0B;
    logic [15:0]   exp_q[$];
    wire  [7:0]    bus_rdata;
    t16wm_pin_type pin_a, pin_b;
    int            n_fail = 0, comparisons = 0, hi, dper[4] = '{256, 256, 510, 510}, dhi[4] = '{65, 191, 128, 382};
    // Clock of 50 MHz
    always #10 clk_sys = ~clk_sys;
    t16wm_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer_tick_enable(tick),
        .capture_event(cap), .dir_out_a(dir_a), .dir_out_b(dir_b), .pin_a(pin_a), .pin_b(pin_b));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask
    // Expected read data is queued before the strobe goes out
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({m, e & m});
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
    endtask
    // Random tick pattern; duty is counted in ticks so it stays exact
    task automatic run(input int n);
        int          t;
        logic [31:0] r;
        t  = 0;
        hi = 0;
        while (t < n) begin
            @(posedge clk_sys);
            if (tick) begin
                t++;
                hi += pin_a.level;
            end
            r = rnd();
            tick  <= r[0];
            dir_a <= r[1];
            dir_b <= r[2];
        end
        tick <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_d) begin
            chk("bus_rdata", {8'h0, exp_q[0][7:0]}, {8'h0, bus_rdata & exp_q[0][15:8]});
            void'(exp_q.pop_front());
        end
        rd_d <= bus_rd;
    end
    task automatic end_of_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog, well beyond the expected run length
    initial begin
        repeat (50000) @(posedge clk_sys);
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(ADDR_CTRL_A, 8'h00, 8'hFF);
        rd(ADDR_CTRL_B, 8'h00, 8'hFF);
        wr(ADDR_CMP_A_LO, 8'h40);
        wr(ADDR_CMP_A_HI, 8'h00);
        wr(ADDR_CTRL_A, 8'h4C);
        rd(ADDR_CTRL_A, 8'h40, 8'hFF);
        chk("pin_a.level", 16'h1, {15'h0, pin_a.level});
        wr(ADDR_CTRL_B, 8'h08);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL_A, fa[i]);
            @(posedge clk_sys);
            // Toggle starts from high, so clear and toggle both end low
            chk("pin_a.level", {15'h0, fa[i][7] & fa[i][6]}, {15'h0, pin_a.level});
            chk("pin_b.level", {15'h0, fa[i][5] & fa[i][4]}, {15'h0, pin_b.level});
        end
        rd(ADDR_STATUS, 8'h00, 8'h07);
        rd(ADDR_CNT_LO, 8'h00, 8'hFF);
        for (int i = 0; i < 11; i++) begin
            wr(ADDR_CTRL_B, {3'h0, om[i][3:2], 3'h0});
            wr(ADDR_CTRL_A, {4'h5, 2'h0, om[i][1:0]});
            repeat (2) @(posedge clk_sys);
            chk("pin_a.override", {15'h0, oa[i]}, {15'h0, pin_a.override});
            chk("pin_b.override", {15'h0, ob[i]}, {15'h0, pin_b.override});
        end
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_CTRL_A, 8'h81);
        @(posedge clk_sys);
        lvl = pin_a.level;
        wr(ADDR_CTRL_A, 8'hCD);
        @(posedge clk_sys);
        chk("pin_a.level", {15'h0, lvl}, {15'h0, pin_a.level});
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_B, {4'h0, i < 2, 3'h0});
            wr(ADDR_CTRL_A, {1'b1, i[0], 5'h0, 1'b1});
            wr(ADDR_STATUS, 8'h1F);
            run(2 * dper[i]);
            run(4 * dper[i]);
            chk("duty_a", 16'(4 * dhi[i]), (hi > 4 * dhi[i] - 9 && hi < 4 * dhi[i] + 9) ? 16'(4 * dhi[i]) : 16'(hi));
            rd(ADDR_STATUS, 8'h01, 8'h01);
        end
        repeat (3) @(posedge clk_sys);
        end_of_test();
    end
endmodule
bind t16wm_top t16wm_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .timer_tick_enable(timer_tick_enable), .capture_event(capture_event), .dir_out_a(dir_out_a),
    .dir_out_b(dir_out_b), .pin_a(pin_a), .pin_b(pin_b));
`default_nettype wire
